/* lncr_pkg.sv */
// link negotiation config bank: offsets, field positions, resets, types
// assumes an 8-bit host register port addressed by byte offset
package lncr_pkg;

	localparam logic [7:0] OFS_NEG_CTRL   = 8'h30;
	localparam logic [7:0] OFS_LINK_STAT  = 8'h31;
	localparam logic [7:0] OFS_CFG_A      = 8'h32;
	localparam logic [7:0] OFS_CFG_B      = 8'h33;

	localparam logic [7:0] RST_NEG_CTRL   = 8'h84;
	localparam logic [7:0] RST_LINK_STAT  = 8'h00;
	localparam logic [7:0] RST_CFG        = 8'h00;
	localparam logic [7:0] RD_NONE        = 8'h00;
	localparam logic [7:0] CTRL_CLEAR     = 8'h00;

	// link status fields
	localparam int B_LINK_SLOW   = 0;
	localparam int B_LINK_FAST   = 1;
	localparam int B_PARTNER     = 2;
	localparam int B_DONE        = 3;
	localparam int B_MODE_FF     = 4;
	localparam int B_MODE_FH     = 5;
	localparam int B_MODE_SF     = 6;
	localparam int B_MODE_SH     = 7;

	// negotiation control fields
	localparam int B_FULL_DUPLEX = 0;
	localparam int B_SPEED       = 1;
	localparam int B_NEG_EN      = 2;
	localparam int B_STATE_LO    = 3;
	localparam int B_STATE_HI    = 5;
	localparam int B_LINK_TEST   = 7;

	// config a fields
	localparam int B_SCR_BYPASS  = 0;
	localparam int B_BUF_WIDTH   = 1;
	localparam int B_SLOW_MEM    = 2;
	localparam int B_ERR_REJECT  = 3;
	localparam int B_EXT_PHY     = 4;
	localparam int B_PAGE_INH    = 5;
	localparam int B_TX_LEN_EN   = 6;
	localparam logic [7:0] MASK_CFG_A = 8'h7f;

	// config b fields
	localparam int B_TX_THR_LO   = 0;
	localparam int B_RX_THR_LO   = 2;
	localparam int B_MEM_LATCH   = 4;
	localparam int B_QUAD_LATCH  = 5;
	localparam int B_ALT_RXREQ   = 6;
	localparam logic [7:0] MASK_CFG_B = 8'h7f;

	typedef enum logic [2:0] {
		NEG_DISABLED  = 3'b000,
		NEG_TX_DIS    = 3'b001,
		NEG_ABILITY   = 3'b010,
		NEG_ACK       = 3'b011,
		NEG_CMPL_ACK  = 3'b100,
		NEG_LINK_GOOD = 3'b101,
		NEG_LINK_CHK  = 3'b110
	} lncr_neg_state_e;

	localparam logic [2:0] RESTART_CODE = 3'b001;

	// resolved mode code from the engine
	typedef enum logic [1:0] {
		MODE_FAST_FULL = 2'b00,
		MODE_FAST_HALF = 2'b01,
		MODE_SLOW_FULL = 2'b10,
		MODE_SLOW_HALF = 2'b11
	} lncr_mode_e;

	// threshold codes in quarters of fifo depth
	localparam logic [1:0] THR_HALF     = 2'b00;
	localparam logic [1:0] THR_QUARTER  = 2'b01;
	localparam logic [1:0] THR_3QUARTER = 2'b10;
	localparam logic [2:0] Q_HALF       = 3'h2;
	localparam logic [2:0] Q_QUARTER    = 3'h1;
	localparam logic [2:0] Q_3QUARTER   = 3'h3;

	typedef struct packed {
		logic [7:0] addr;
		logic       wr;
		logic       rd;
		logic [7:0] wdata;
	} lncr_req_s;

	typedef struct packed {
		logic            link_slow;
		logic            link_fast;
		logic            partner_negotiates;
		lncr_neg_state_e state;
		lncr_mode_e      mode;
	} lncr_eng_s;

	typedef struct packed {
		logic       full_duplex;
		logic       fast_speed;
		logic       negotiation_enable;
		logic       link_test_enable;
		logic       scrambler_bypass;
		logic       buffer_width_select;
		logic       slow_memory_select;
		logic       error_packet_reject;
		logic       external_phy_select;
		logic       page_auto_advance;
		logic       tx_length_count_enable;
		logic [2:0] tx_threshold_quarters;
		logic [2:0] rx_threshold_quarters;
		logic       memory_early_latch_enable;
		logic       quad_fifo_early_latch_enable;
		logic       alt_rx_request_timing_enable;
	} lncr_cfg_s;

endpackage

/* lncr_regs.sv */
// link negotiation control/status and controller configuration registers
// assumes host strobes and engine status are synchronous to clk_sys
//
// Contract
// RULE1 - forced duplex bit applies only without negotiation
// RULE2 - speed select default 10, set gives 100
// RULE3 - enable resets 1; write 001 restarts
// RULE4 - state field read-only except restart write 001
// RULE5 - state field reports engine arbitration state codes
// RULE6 - link test clear forces good 10 link; code forces it only while cfg.fast_speed is clear
// RULE7 - status bits 0/1 show 10/100 link good
// RULE8 - bit 2 shows partner can negotiate
// RULE9 - done bit set on normal completion only
// RULE10 - exactly one resolved mode bit when settled
// RULE11 - scrambler bypass default 0, set disables scrambling
// RULE12 - buffer width 0 byte, 1 sixteen bits
// RULE13 - slow memory bit relaxes buffer memory timing
// RULE14 - error reject set drops errored packets
// RULE15 - external transceiver select switches to mii
// RULE16 - page inhibit stops automatic page advance
// RULE17 - tx length count enable for wide hosts
// RULE18 - thresholds half, quarter, three quarters; 11 reserved
// RULE19 - three early latch/timing options default off
// RULE20 - resets 84h, 00h, 00h, 00h
// RULE21 - status register ignores host writes
`timescale 1ns/1ns
`default_nettype none
module lncr_regs
(
	// clock and reset
	input  wire logic                 clk_sys,
	input  wire logic                 sys_rst,
	// host register port
	input  wire lncr_pkg::lncr_req_s  host_req,
	output logic [7:0]                host_rdata,
	// negotiation engine
	input  wire lncr_pkg::lncr_eng_s  eng,
	output logic                      neg_restart,
	// configuration to the controller
	output lncr_pkg::lncr_cfg_s       cfg
);

	////////////////////////////////////////////////////////////////////////
	// functions

	function automatic logic [2:0] thr_quarters(input logic [1:0] code);
		logic [2:0] q;
		q = lncr_pkg::Q_HALF;
		unique case (code)
			lncr_pkg::THR_QUARTER:  q = lncr_pkg::Q_QUARTER;
			lncr_pkg::THR_3QUARTER: q = lncr_pkg::Q_3QUARTER;
			default:                q = lncr_pkg::Q_HALF;
		endcase
		return q;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// control registers

	logic [7:0] neg_ctrl_r;
	logic [7:0] cfg_a_r;
	logic [7:0] cfg_b_r;
	logic [7:0] link_stat_r;
	logic [7:0] link_stat_nxt;
	logic       wr_ctrl;
	logic       neg_done;

	assign wr_ctrl = host_req.wr && (host_req.addr == lncr_pkg::OFS_NEG_CTRL);

	// state field and reserved bit never stored
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			neg_ctrl_r <= lncr_pkg::RST_NEG_CTRL; // [RULE20] [RULE3]
		else if (wr_ctrl)
		begin
			neg_ctrl_r <= lncr_pkg::CTRL_CLEAR; // [RULE4]
			neg_ctrl_r[lncr_pkg::B_FULL_DUPLEX] <= host_req.wdata[lncr_pkg::B_FULL_DUPLEX];
			neg_ctrl_r[lncr_pkg::B_SPEED]       <= host_req.wdata[lncr_pkg::B_SPEED];
			neg_ctrl_r[lncr_pkg::B_NEG_EN]      <= host_req.wdata[lncr_pkg::B_NEG_EN];
			neg_ctrl_r[lncr_pkg::B_LINK_TEST]   <= host_req.wdata[lncr_pkg::B_LINK_TEST];
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			cfg_a_r <= lncr_pkg::RST_CFG; // [RULE20]
		else if (host_req.wr && host_req.addr == lncr_pkg::OFS_CFG_A)
			cfg_a_r <= host_req.wdata & lncr_pkg::MASK_CFG_A;
	end

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			cfg_b_r <= lncr_pkg::RST_CFG; // [RULE20]
		else if (host_req.wr && host_req.addr == lncr_pkg::OFS_CFG_B)
			cfg_b_r <= host_req.wdata & lncr_pkg::MASK_CFG_B;
	end

	// restart pulse: write of 001 with enable set in the same write
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			neg_restart <= 1'b0;
		else
			neg_restart <= wr_ctrl && host_req.wdata[lncr_pkg::B_NEG_EN]
				&& host_req.wdata[lncr_pkg::B_STATE_HI:lncr_pkg::B_STATE_LO]
				== lncr_pkg::RESTART_CODE; // [RULE3] [RULE4]
	end

	////////////////////////////////////////////////////////////////////////
	// link status, updated from the engine and the control register, never by host writes

	assign neg_done = neg_ctrl_r[lncr_pkg::B_NEG_EN]
		&& eng.state == lncr_pkg::NEG_LINK_GOOD; // [RULE9]

	always_comb
	begin
		link_stat_nxt = lncr_pkg::RST_LINK_STAT;
		link_stat_nxt[lncr_pkg::B_LINK_SLOW] = eng.link_slow
			|| (!neg_ctrl_r[lncr_pkg::B_LINK_TEST] && !cfg.fast_speed); // [RULE6] [RULE7]
		link_stat_nxt[lncr_pkg::B_LINK_FAST] = eng.link_fast; // [RULE7]
		link_stat_nxt[lncr_pkg::B_PARTNER] = eng.partner_negotiates; // [RULE8]
		link_stat_nxt[lncr_pkg::B_DONE] = neg_done; // [RULE9]
		if (neg_done)
		begin
			unique case (eng.mode) // [RULE10]
				lncr_pkg::MODE_FAST_FULL: link_stat_nxt[lncr_pkg::B_MODE_FF] = 1'b1;
				lncr_pkg::MODE_FAST_HALF: link_stat_nxt[lncr_pkg::B_MODE_FH] = 1'b1;
				lncr_pkg::MODE_SLOW_FULL: link_stat_nxt[lncr_pkg::B_MODE_SF] = 1'b1;
				lncr_pkg::MODE_SLOW_HALF: link_stat_nxt[lncr_pkg::B_MODE_SH] = 1'b1;
			endcase
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			link_stat_r <= lncr_pkg::RST_LINK_STAT; // [RULE20]
		else
			link_stat_r <= link_stat_nxt; // [RULE21]
	end

	////////////////////////////////////////////////////////////////////////
	// read path

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			host_rdata <= lncr_pkg::RD_NONE;
		else if (host_req.rd)
		begin
			unique case (host_req.addr)
				lncr_pkg::OFS_NEG_CTRL:
				begin
					host_rdata <= neg_ctrl_r;
					host_rdata[lncr_pkg::B_STATE_HI:lncr_pkg::B_STATE_LO] <=
						neg_ctrl_r[lncr_pkg::B_NEG_EN] ? eng.state
						: lncr_pkg::NEG_DISABLED; // [RULE5]
				end
				lncr_pkg::OFS_LINK_STAT: host_rdata <= link_stat_r;
				lncr_pkg::OFS_CFG_A:     host_rdata <= cfg_a_r;
				lncr_pkg::OFS_CFG_B:     host_rdata <= cfg_b_r;
				default:                 host_rdata <= lncr_pkg::RD_NONE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// effective configuration

	always_comb
	begin
		cfg.negotiation_enable = neg_ctrl_r[lncr_pkg::B_NEG_EN];
		cfg.link_test_enable   = neg_ctrl_r[lncr_pkg::B_LINK_TEST];
		if (neg_done)
		begin
			cfg.full_duplex = eng.mode == lncr_pkg::MODE_FAST_FULL
				|| eng.mode == lncr_pkg::MODE_SLOW_FULL;
			cfg.fast_speed  = eng.mode == lncr_pkg::MODE_FAST_FULL
				|| eng.mode == lncr_pkg::MODE_FAST_HALF;
		end
		else
		begin
			cfg.full_duplex = !neg_ctrl_r[lncr_pkg::B_NEG_EN]
				&& neg_ctrl_r[lncr_pkg::B_FULL_DUPLEX]; // [RULE1]
			cfg.fast_speed  = neg_ctrl_r[lncr_pkg::B_SPEED]; // [RULE2]
		end
		cfg.scrambler_bypass       = cfg_a_r[lncr_pkg::B_SCR_BYPASS]; // [RULE11]
		cfg.buffer_width_select    = cfg_a_r[lncr_pkg::B_BUF_WIDTH]; // [RULE12]
		cfg.slow_memory_select     = cfg_a_r[lncr_pkg::B_SLOW_MEM]; // [RULE13]
		cfg.error_packet_reject    = cfg_a_r[lncr_pkg::B_ERR_REJECT]; // [RULE14]
		cfg.external_phy_select    = cfg_a_r[lncr_pkg::B_EXT_PHY]; // [RULE15]
		cfg.page_auto_advance      = !cfg_a_r[lncr_pkg::B_PAGE_INH]; // [RULE16]
		cfg.tx_length_count_enable = cfg_a_r[lncr_pkg::B_TX_LEN_EN]; // [RULE17]
		cfg.tx_threshold_quarters  =
			thr_quarters(cfg_b_r[lncr_pkg::B_TX_THR_LO +: 2]); // [RULE18]
		cfg.rx_threshold_quarters  =
			thr_quarters(cfg_b_r[lncr_pkg::B_RX_THR_LO +: 2]); // [RULE18]
		cfg.memory_early_latch_enable    = cfg_b_r[lncr_pkg::B_MEM_LATCH]; // [RULE19]
		cfg.quad_fifo_early_latch_enable = cfg_b_r[lncr_pkg::B_QUAD_LATCH]; // [RULE19]
		cfg.alt_rx_request_timing_enable = cfg_b_r[lncr_pkg::B_ALT_RXREQ]; // [RULE19]
	end

endmodule
`default_nettype wire

/* lncr_chk.sv */
// checker for the link negotiation config bank
// assumes a bind onto lncr_regs, one clock
`timescale 1ns/1ns
`default_nettype none
module lncr_chk
(
	// clock and reset
	input wire logic                clk_sys,
	input wire logic                sys_rst,
	// watched ports
	input wire lncr_pkg::lncr_req_s host_req,
	input wire logic [7:0]          host_rdata,
	input wire lncr_pkg::lncr_eng_s eng,
	input wire logic                neg_restart,
	input wire lncr_pkg::lncr_cfg_s cfg
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	logic [7:0] a;
	logic [7:0] d;
	logic       r;
	logic       w;
	assign a = host_req.addr;
	assign d = host_req.wdata;
	assign r = host_req.rd;
	assign w = host_req.wr;
	AST_RESTART: assert property (neg_restart == $past(w && a == 8'h30 && d[5:2] == 4'h3))
		else $error("restart pulse wrong");
	AST_FORCE: assert property (w && a == 8'h30 && !d[2] |=>
		{cfg.fast_speed, cfg.full_duplex} == $past(d[1:0])) else $error("forced mode wrong");
	AST_STATE: assert property (r && a == 8'h30 |=> host_rdata[6:3] ==
		($past(cfg.negotiation_enable) ? {1'b0, $past(eng.state)} : 4'h0)) else $error("state wrong");
	AST_LINK: assert property (r && a == 8'h31 |=>
		host_rdata[2:1] == $past({eng.partner_negotiates, eng.link_fast}, 2)) else $error("link bad");
	AST_DONE: assert property (r && a == 8'h31 |=>
		host_rdata[3] == $past(cfg.negotiation_enable && eng.state == 3'h5, 2)) else $error("done bad");
	AST_ONEHOT: assert property (r && a == 8'h31 |=> $countones(host_rdata[7:4]) == host_rdata[3])
		else $error("mode bits wrong");
	AST_CFGA: assert property (w && a == 8'h32 |=>
		{cfg.scrambler_bypass, cfg.external_phy_select, cfg.page_auto_advance} == $past({d[0], d[4], !d[5]}))
		else $error("config a wrong");
	AST_THR: assert property (w && a == 8'h33 |=> cfg.tx_threshold_quarters ==
		($past(d[1:0]) == 2'h1 ? 3'h1 : $past(d[1:0]) == 2'h2 ? 3'h3 : 3'h2)) else $error("thr wrong");
	cover property (neg_restart);
	cover property (r && a == 8'h31 ##1 host_rdata[3]);
	cover property (w && a == 8'h33 && d[1:0] == 2'h3);
endmodule
bind lncr_regs lncr_chk u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst), .host_req(host_req),
	.host_rdata(host_rdata), .eng(eng), .neg_restart(neg_restart), .cfg(cfg));
`default_nettype wire

/* lncr_eng_model.sv */
// negotiation engine model feeding the engine status inputs
// assumes restart pulses from lncr_regs, one clock
`timescale 1ns/1ns
`default_nettype none
module lncr_eng_model
(
	// clock and reset
	input wire logic                 clk_sys,
	input wire logic                 sys_rst,
	// control
	input wire logic                 neg_restart,
	input wire logic                 has_nway,
	input wire lncr_pkg::lncr_mode_e mode_sel,
	// engine status
	output var lncr_pkg::lncr_eng_s  eng
);
	logic [2:0] st_r;
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			st_r <= 3'h0;
		else if (neg_restart)
			st_r <= 3'h1;
		else if (st_r != 3'h0 && st_r < 3'h5)
			st_r <= (!has_nway && st_r == 3'h2) ? 3'h6 : st_r + 3'h1;
	end
	assign eng.state = lncr_pkg::lncr_neg_state_e'(st_r);
	assign eng.mode = mode_sel;
	assign eng.partner_negotiates = has_nway && st_r != 3'h0;
	assign eng.link_fast = st_r == 3'h5 && !mode_sel[1];
	assign eng.link_slow = st_r == 3'h5 && mode_sel[1];
endmodule
`default_nettype wire

/* lncr_regs_tb_top.sv */
// testbench for the link negotiation config bank
// assumes lncr_regs, lncr_eng_model and the bound checker
`timescale 1ns/1ns
`default_nettype none
module lncr_regs_tb_top;
	logic                 clk_sys = 1'b0;
	logic                 sys_rst = 1'b1;
	lncr_pkg::lncr_req_s  req = '0;
	logic [7:0]           rdata;
	lncr_pkg::lncr_eng_s  eng;
	logic                 restart;
	lncr_pkg::lncr_cfg_s  cfg;
	logic                 nway = 1'b1;
	lncr_pkg::lncr_mode_e mode = lncr_pkg::MODE_FAST_FULL;
	int                   errors = 0;
	int                   tests_run = 0;
	int                   cyc = 0;
	always #25 clk_sys = ~clk_sys;
	lncr_regs dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .host_req(req), .host_rdata(rdata),
		.eng(eng), .neg_restart(restart), .cfg(cfg));
	lncr_eng_model u_eng (.clk_sys(clk_sys), .sys_rst(sys_rst), .neg_restart(restart),
		.has_nway(nway), .mode_sel(mode), .eng(eng));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
		@(negedge clk_sys);
		req.wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(negedge clk_sys);
		req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
		@(negedge clk_sys);
		req.rd = 1'b0;
		chk(rdata, exp);
	endtask
	task automatic t_reset;
		rd(8'h30, 8'h84);
		rd(8'h31, 8'h00);
		rd(8'h32, 8'h00);
		rd(8'h33, 8'h00);
		rd(8'h40, 8'h00);
		chk({cfg.page_auto_advance, cfg.tx_threshold_quarters, cfg.rx_threshold_quarters, 1'b0}, 8'ha4);
		chk({6'h0, cfg.negotiation_enable, cfg.link_test_enable}, 8'h03);
		$display("reset test done");
	endtask
	task automatic t_cfg;
		logic [7:0] q [4] = '{8'h12, 8'h09, 8'h1b, 8'h12};
		wr(8'h32, 8'hff);
		rd(8'h32, 8'h7f);
		chk({cfg.scrambler_bypass, cfg.buffer_width_select, cfg.slow_memory_select,
			cfg.error_packet_reject, cfg.external_phy_select, cfg.page_auto_advance,
			cfg.tx_length_count_enable, 1'b0}, 8'hfa);
		for (int i = 0; i < 4; i++)
		begin
			wr(8'h33, 8'h70 | 8'(i * 5));
			chk({2'h0, cfg.tx_threshold_quarters, cfg.rx_threshold_quarters}, q[i]);
		end
		chk({5'h0, cfg.memory_early_latch_enable, cfg.quad_fifo_early_latch_enable,
			cfg.alt_rx_request_timing_enable}, 8'h07);
		rd(8'h33, 8'h7f);
		$display("config test done");
	endtask
	task automatic t_force;
		wr(8'h30, 8'h03);
		chk({6'h0, cfg.fast_speed, cfg.full_duplex}, 8'h03);
		rd(8'h30, 8'h03);
		wr(8'h30, 8'h87);
		chk({6'h0, cfg.fast_speed, cfg.full_duplex}, 8'h02);
		wr(8'h30, 8'h00);
		rd(8'h31, 8'h01);
		wr(8'h30, 8'h84);
		$display("forced test done");
	endtask
	task automatic t_neg;
		for (int m = 0; m < 4; m++)
		begin
			mode = lncr_pkg::lncr_mode_e'(m);
			wr(8'h30, 8'h8c);
			repeat (8) @(negedge clk_sys);
			rd(8'h31, 8'(8'h10 << m) | 8'h0c | (m < 2 ? 8'h02 : 8'h01));
			rd(8'h30, 8'hac);
			chk({6'h0, cfg.fast_speed, cfg.full_duplex}, {6'h0, m < 2, m % 2 == 0});
		end
		wr(8'h31, 8'h00);
		rd(8'h31, 8'h8d);
		nway = 1'b0;
		wr(8'h30, 8'h8c);
		repeat (8) @(negedge clk_sys);
		rd(8'h31, 8'h00);
		rd(8'h30, 8'hb4);
		$display("negotiation test done");
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (8) @(posedge clk_sys);
		@(negedge clk_sys);
		sys_rst = 1'b0;
		t_reset();
		t_cfg();
		t_force();
		t_neg();
		final_report();
	end
	always @(posedge clk_sys)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			errors++;
			final_report();
		end
	end
endmodule
`default_nettype wire
